// ### ismt_pkg.sv
// Contract
// R01 - Address match or general call sets addressed flag
// R02 - Detect-disable blocks match and general call
// R03 - Free format: first word sets addressed flag
// R04 - Data buffer read or write clears addressed flag
// R05 - All-zero first word sets general-call flag
// R06 - Detect-disable keeps general-call flag zero
// R07 - Start or stop clears general-call flag
// R08 - SDA captured at each SCL rise
// R09 - Last bit holds acknowledge at interrupt
// R10 - Free format treats all bits as data
// R11 - Software powers, checks pins, sets defaults
// R12 - Software programs address, slave receiver defaults
// R13 - Software checks bus free, loads address
// R14 - Start command sends start then address
// R15 - SCL high one high time after start
// R16 - Ninth falling edge: interrupt, clear, hold low; the code does this in master mode only, never as slave
// R17 - Direction updates transmit bit only on acknowledge
// R18 - Software avoids buffer writes mid-transfer
// R19 - Software starts within bus-free time window
// R20 - Handler stops on NACK, else writes next
// R21 - Buffer write sends next word, then interrupts
// R22 - Handler checks master then transmit status
// R23 - Bus-busy write zero starts stop sequence
// R24 - Seven address bits compared, eighth is direction
package ismt_pkg;

  localparam int          LINK_CLK_NS    = 125;
  localparam int          SCL_UNIT_NS    = 500;
  localparam int          SCL_UNIT_CYC   = (SCL_UNIT_NS + LINK_CLK_NS - 1) / LINK_CLK_NS;
  localparam int          TIMER_W        = 10;
  localparam logic [9:0]  SCL_UNIT_CNT   = 10'(SCL_UNIT_CYC);
  localparam logic [2:0]  BC_FULL_WORD   = 3'h0;
  localparam logic [3:0]  FULL_WORD_BITS = 4'h8;
  localparam logic [3:0]  LAST_ADDR_RISE = 4'h7;
  localparam logic [7:0]  GENERAL_CALL   = 8'h00;
  localparam logic [1:0]  SYNC_IDLE      = 2'h3;
  localparam logic        PIN_RESET      = 1'b1;

  typedef enum logic [2:0] {
    ISMT_CMD_DATA,
    ISMT_CMD_START,
    ISMT_CMD_STOP,
    ISMT_CMD_RESUME,
    ISMT_CMD_READ
  } ismt_cmd_t;

  typedef enum logic [2:0] {
    ISMT_IDLE,
    ISMT_START_HOLD,
    ISMT_BIT_LOW,
    ISMT_BIT_HIGH,
    ISMT_HOLD_LOW,
    ISMT_STOP_LOW,
    ISMT_STOP_HIGH
  } ismt_state_t;

  typedef struct packed {
    logic       ack_en;
    logic       addr_det_dis;
    logic       free_fmt;
    logic [2:0] bit_cnt;
    logic [2:0] time_code;
    logic [6:0] own_addr;
  } ismt_cfg_t;

  typedef struct packed {
    logic master_select;
    logic trx;
    logic bb;
    logic pin;
    logic addressed_as_slave_flag;
    logic ad0;
    logic lrb;
  } ismt_stat_t;

  localparam ismt_stat_t STAT_RESET = '{master_select: 1'b0, trx: 1'b0, bb: 1'b0, pin: PIN_RESET,
                                        addressed_as_slave_flag: 1'b0, ad0: 1'b0, lrb: 1'b0};

endpackage : ismt_pkg

// ### ismt_core.sv
`timescale 1ns/1ns
module ismt_core (
  input  wire logic       clock_in,
  input  wire logic       sys_rst_in,
  input  wire logic       link_clk_in,
  input  wire logic       ctrl_wr_in,
  input  wire logic       ctrl_master_select_in,
  input  wire logic       ctrl_transmit_in,
  input  wire logic       ctrl_bus_busy_in,
  input  wire logic       ctrl_service_req_in,
  input  wire logic       data_wr_in,
  input  wire logic [7:0] data_wr_data_in,
  input  wire logic       data_rd_in,
  input  wire logic       ack_clock_enable_in,
  input  wire logic       address_detect_disable_in,
  input  wire logic       free_format_select_in,
  input  wire logic [2:0] word_bit_count_in,
  input  wire logic [2:0] scl_time_code_in,
  input  wire logic [6:0] own_slave_address_in,
  input  wire logic       clock_line_pin_in,
  input  wire logic       data_line_pin_in,
  output logic       [7:0] data_rd_data_out,
  output logic             cmd_busy_out,
  output logic             master_select_out,
  output logic             transmit_select_out,
  output logic             bus_busy_flag_out,
  output logic             service_request_out,
  output logic             addressed_as_slave_flag_out,
  output logic             general_call_flag_out,
  output logic             last_received_bit_out,
  output logic             bus_interface_irq_out,
  output logic             clock_line_pin_out,
  output logic             clock_line_pin_oe_out,
  output logic             data_line_pin_out,
  output logic             data_line_pin_oe_out
);

  typedef struct packed {
    logic                cmd_tog;
    ismt_pkg::ismt_cmd_t kind;
    logic [7:0]          data;
    logic [1:0]          ack_s;
    logic                busy;
    logic [1:0]          irq_s;
    logic                irq_d;
    logic                irq;
    ismt_pkg::ismt_stat_t st0;
    ismt_pkg::ismt_stat_t st1;
    logic [7:0]          rd0;
    logic [7:0]          rd1;
  } ismt_cpu_t;

  typedef struct packed {
    logic [1:0]             rst_s;
    logic [1:0]             scl_s;
    logic [1:0]             sda_s;
    logic                   scl_d;
    logic                   sda_d;
    logic [1:0]             cmd_s;
    logic                   ack_tog;
    ismt_pkg::ismt_cfg_t    cfg0;
    ismt_pkg::ismt_cfg_t    cfg;
    ismt_pkg::ismt_state_t  state;
    logic [ismt_pkg::TIMER_W-1:0] timer;
    logic [3:0]             bitn;
    logic [7:0]             sh;
    logic                   dir;
    logic                   addr_word;
    logic                   scl_oe;
    logic                   sda_oe;
    ismt_pkg::ismt_stat_t   st;
    logic                   first;
    logic [3:0]             rcnt;
    logic [7:0]             rx;
    logic                   irq_tog;
  } ismt_link_t;

  ismt_cpu_t           c;
  ismt_cpu_t           next_c;
  ismt_link_t          l;
  ismt_link_t          next_l;
  ismt_pkg::ismt_cfg_t cfg_in;

  assign cfg_in = '{ack_en: ack_clock_enable_in, addr_det_dis: address_detect_disable_in,
                    free_fmt: free_format_select_in, bit_cnt: word_bit_count_in,
                    time_code: scl_time_code_in, own_addr: own_slave_address_in};

  // Open-drain drive for the bit at position bitn of the word
  function automatic logic drive_bit(input logic [7:0] sh, input logic [3:0] bitn,
                                     input logic [3:0] nbits, input logic trx);
    logic oe;
    oe = 1'b0;
    if (bitn < nbits) begin
      oe = trx & ~sh[7];
    end else if (bitn == nbits) begin
      oe = ~trx;
    end
    return oe;
  endfunction : drive_bit

  // Register side, system clock
  always_comb begin : cpu_next
    next_c       = c;
    next_c.ack_s = {c.ack_s[0], l.ack_tog};
    next_c.irq_s = {c.irq_s[0], l.irq_tog};
    next_c.irq_d = c.irq_s[1];
    next_c.irq   = (c.irq_s[1] != c.irq_d);
    next_c.st0   = l.st;
    next_c.st1   = c.st0;
    next_c.rd0   = l.st.master_select ? l.sh : l.rx;
    next_c.rd1   = c.rd0;
    if (c.cmd_tog == c.ack_s[1]) begin
      if (data_wr_in) begin
        next_c.kind    = ismt_pkg::ISMT_CMD_DATA;
        next_c.data    = data_wr_data_in;
        next_c.cmd_tog = ~c.cmd_tog;
      end else if (ctrl_wr_in && ctrl_service_req_in) begin
        if (ctrl_master_select_in && ctrl_transmit_in) begin
          next_c.kind = ctrl_bus_busy_in ? ismt_pkg::ISMT_CMD_START : ismt_pkg::ISMT_CMD_STOP;
        end else begin
          next_c.kind = ismt_pkg::ISMT_CMD_RESUME;
        end
        next_c.cmd_tog = ~c.cmd_tog;
      end else if (data_rd_in) begin
        next_c.kind    = ismt_pkg::ISMT_CMD_READ;
        next_c.cmd_tog = ~c.cmd_tog;
      end
    end
    next_c.busy = (next_c.cmd_tog != next_c.ack_s[1]);
    if (sys_rst_in) begin
      next_c     = '0;
      next_c.st0 = ismt_pkg::STAT_RESET;
      next_c.st1 = ismt_pkg::STAT_RESET;
    end
  end

  always_ff @(posedge clock_in) begin
    c <= next_c;
  end

  // Link side, link clock
  always_comb begin : link_next
    logic [9:0] half;
    logic [3:0] nbits;
    logic [3:0] total;
    logic       rise;
    logic       start_det;
    logic       stop_det;
    logic       sda;
    logic [7:0] word;
    half      = ismt_pkg::SCL_UNIT_CNT << l.cfg.time_code;
    nbits     = (l.cfg.bit_cnt == ismt_pkg::BC_FULL_WORD) ? ismt_pkg::FULL_WORD_BITS
                                                           : {1'b0, l.cfg.bit_cnt};
    total     = nbits + {3'h0, l.cfg.ack_en};
    sda       = l.sda_s[1];
    rise      = l.scl_s[1] & ~l.scl_d;
    start_det = l.scl_s[1] & l.scl_d & l.sda_d & ~sda;
    stop_det  = l.scl_s[1] & l.scl_d & ~l.sda_d & sda;
    word      = {l.rx[6:0], sda};
    next_l       = l;
    next_l.rst_s = {l.rst_s[0], sys_rst_in};
    next_l.scl_s = {l.scl_s[0], clock_line_pin_in};
    next_l.sda_s = {l.sda_s[0], data_line_pin_in};
    next_l.scl_d = l.scl_s[1];
    next_l.sda_d = l.sda_s[1];
    next_l.cmd_s = {l.cmd_s[0], c.cmd_tog};
    next_l.cfg0  = cfg_in;
    next_l.cfg   = l.cfg0;

    if (l.cmd_s[1] != l.ack_tog) begin
      next_l.ack_tog = l.cmd_s[1];
      case (c.kind)
        ismt_pkg::ISMT_CMD_DATA: begin
          next_l.sh     = c.data;
          next_l.st.pin = 1'b1; // R21
          next_l.st.addressed_as_slave_flag = 1'b0; // R04
          if (l.state == ismt_pkg::ISMT_HOLD_LOW) begin
            next_l.state  = ismt_pkg::ISMT_BIT_LOW; // R21
            next_l.timer  = half - 10'h001;
            next_l.bitn   = 4'h0;
            next_l.sda_oe = drive_bit(c.data, 4'h0, nbits, l.st.trx);
          end
        end
        ismt_pkg::ISMT_CMD_START: begin
          if (!l.st.bb && l.state == ismt_pkg::ISMT_IDLE) begin
            next_l.st.master_select    = 1'b1; // R14
            next_l.st.trx    = 1'b1;
            next_l.st.pin    = 1'b1;
            next_l.dir       = l.sh[0];
            next_l.addr_word = 1'b1;
            next_l.state     = ismt_pkg::ISMT_START_HOLD;
            next_l.sda_oe    = 1'b1;
            next_l.timer     = half - 10'h001; // R15
          end
        end
        ismt_pkg::ISMT_CMD_STOP: begin
          if (l.st.bb && l.st.master_select && l.state == ismt_pkg::ISMT_HOLD_LOW) begin
            next_l.st.pin = 1'b1;
            next_l.state  = ismt_pkg::ISMT_STOP_LOW; // R23
            next_l.sda_oe = 1'b1;
            next_l.timer  = half - 10'h001;
          end
        end
        ismt_pkg::ISMT_CMD_RESUME: begin
          next_l.st.pin = 1'b1;
          if (l.state == ismt_pkg::ISMT_HOLD_LOW) begin
            next_l.state  = ismt_pkg::ISMT_BIT_LOW;
            next_l.timer  = half - 10'h001;
            next_l.bitn   = 4'h0;
            next_l.sda_oe = drive_bit(l.sh, 4'h0, nbits, l.st.trx);
          end
        end
        ismt_pkg::ISMT_CMD_READ: begin
          next_l.st.addressed_as_slave_flag = 1'b0; // R04
        end
        default: begin
          next_l.ack_tog = l.cmd_s[1];
        end
      endcase
    end

    case (l.state)
      ismt_pkg::ISMT_IDLE: begin
        next_l.scl_oe = 1'b0;
      end
      ismt_pkg::ISMT_START_HOLD: begin
        if (l.timer != '0) begin
          next_l.timer = l.timer - 10'h001;
        end else begin
          next_l.scl_oe = 1'b1; // R15
          next_l.state  = ismt_pkg::ISMT_BIT_LOW;
          next_l.timer  = half - 10'h001;
          next_l.bitn   = 4'h0;
          next_l.sda_oe = drive_bit(l.sh, 4'h0, nbits, l.st.trx); // R14
        end
      end
      ismt_pkg::ISMT_BIT_LOW: begin
        if (l.timer != '0) begin
          next_l.timer = l.timer - 10'h001;
        end else begin
          next_l.scl_oe = 1'b0;
          next_l.state  = ismt_pkg::ISMT_BIT_HIGH;
          next_l.timer  = half - 10'h001;
        end
      end
      ismt_pkg::ISMT_BIT_HIGH: begin
        // Wait out any stretching before the high time runs
        if (l.scl_s[1]) begin
          if (l.timer != '0) begin
            next_l.timer = l.timer - 10'h001;
          end else begin
            next_l.scl_oe = 1'b1;
            next_l.bitn   = l.bitn + 4'h1;
            if (l.bitn < nbits) begin
              next_l.sh = {l.sh[6:0], sda};
            end
            if (l.bitn + 4'h1 == total) begin
              next_l.state     = ismt_pkg::ISMT_HOLD_LOW; // R16
              next_l.st.pin    = 1'b0; // R16
              next_l.irq_tog   = ~l.irq_tog; // R16 R21
              next_l.sda_oe    = 1'b0;
              next_l.addr_word = 1'b0;
              if (l.addr_word && l.cfg.ack_en && !l.st.lrb && !l.cfg.free_fmt) begin
                next_l.st.trx = ~l.dir; // R17
              end
            end else begin
              next_l.state  = ismt_pkg::ISMT_BIT_LOW;
              next_l.timer  = half - 10'h001;
              next_l.sda_oe = drive_bit({l.sh[6:0], sda}, l.bitn + 4'h1, nbits, l.st.trx);
            end
          end
        end
      end
      ismt_pkg::ISMT_HOLD_LOW: begin
        next_l.scl_oe = 1'b1; // R16
      end
      ismt_pkg::ISMT_STOP_LOW: begin
        if (l.timer != '0) begin
          next_l.timer = l.timer - 10'h001;
        end else begin
          next_l.scl_oe = 1'b0;
          next_l.state  = ismt_pkg::ISMT_STOP_HIGH;
          next_l.timer  = half - 10'h001;
        end
      end
      ismt_pkg::ISMT_STOP_HIGH: begin
        if (l.scl_s[1]) begin
          if (l.timer != '0) begin
            next_l.timer = l.timer - 10'h001;
          end else begin
            next_l.sda_oe = 1'b0; // R23
            next_l.state  = ismt_pkg::ISMT_IDLE;
          end
        end
      end
      default: begin
        next_l.state = ismt_pkg::ISMT_IDLE;
      end
    endcase

    // Bus monitor; detected events win over command clears
    if (rise) begin
      next_l.st.lrb = sda; // R08 R09
      next_l.rx     = word;
      if (l.first) begin
        next_l.rcnt = l.rcnt + 4'h1;
        if (l.rcnt == ismt_pkg::LAST_ADDR_RISE) begin
          next_l.first = 1'b0;
          if (!l.st.master_select) begin
            if (l.cfg.free_fmt) begin
              next_l.st.addressed_as_slave_flag = 1'b1; // R03 R10
            end else if (!l.cfg.addr_det_dis) begin // R02 R06
              if (word == ismt_pkg::GENERAL_CALL) begin
                next_l.st.ad0 = 1'b1; // R05
                next_l.st.addressed_as_slave_flag = 1'b1; // R01
              end else if (word[7:1] == l.cfg.own_addr) begin
                next_l.st.addressed_as_slave_flag = 1'b1; // R01 R24
                next_l.st.trx = word[0]; // R10 R24
              end
            end
          end
        end
      end
    end
    if (start_det) begin
      next_l.st.bb  = 1'b1;
      next_l.st.ad0 = 1'b0; // R07
      next_l.first  = 1'b1;
      next_l.rcnt   = 4'h0;
    end
    if (stop_det) begin
      next_l.st.bb  = 1'b0;
      next_l.st.ad0 = 1'b0; // R07
      next_l.st.master_select = 1'b0;
      next_l.st.trx = 1'b0;
      next_l.first  = 1'b0;
    end

    if (l.rst_s[1]) begin
      next_l           = '0;
      next_l.rst_s     = {l.rst_s[0], sys_rst_in};
      next_l.scl_s     = ismt_pkg::SYNC_IDLE;
      next_l.sda_s     = ismt_pkg::SYNC_IDLE;
      next_l.scl_d     = 1'b1;
      next_l.sda_d     = 1'b1;
      next_l.st        = ismt_pkg::STAT_RESET;
      next_l.state     = ismt_pkg::ISMT_IDLE;
    end
  end

  always_ff @(posedge link_clk_in) begin
    l <= next_l;
  end

  assign data_rd_data_out            = c.rd1;
  assign cmd_busy_out                = c.busy;
  assign master_select_out           = c.st1.master_select;
  assign transmit_select_out         = c.st1.trx;
  assign bus_busy_flag_out           = c.st1.bb;
  assign service_request_out         = c.st1.pin;
  assign addressed_as_slave_flag_out = c.st1.addressed_as_slave_flag;
  assign general_call_flag_out       = c.st1.ad0;
  assign last_received_bit_out       = c.st1.lrb;
  assign bus_interface_irq_out       = c.irq;
  assign clock_line_pin_out          = 1'b0;
  assign clock_line_pin_oe_out       = l.scl_oe;
  assign data_line_pin_out           = 1'b0;
  assign data_line_pin_oe_out        = l.sda_oe;

endmodule : ismt_core

// ### ismt_properties.sv
`timescale 1ns/1ns
module ismt_properties (
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic data_wr_in,
  input wire logic data_rd_in,
  input wire logic address_detect_disable_in,
  input wire logic cmd_busy_out,
  input wire logic master_select_out,
  input wire logic bus_busy_flag_out,
  input wire logic service_request_out,
  input wire logic addressed_as_slave_flag_out,
  input wire logic general_call_flag_out,
  input wire logic bus_interface_irq_out,
  input wire logic clock_line_pin_oe_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);

  property p_irq_pulse; bus_interface_irq_out |=> !bus_interface_irq_out; endproperty
  a_irq_pulse: assert property (p_irq_pulse)
    else $error("irq longer than one cycle");
  property p_pin_clear; bus_interface_irq_out |-> ##[0:8] !service_request_out; endproperty
  a_pin_clear: assert property (p_pin_clear)
    else $error("service request not cleared at irq");
  property p_hold_low;
    master_select_out && !service_request_out |-> clock_line_pin_oe_out;
  endproperty
  a_hold_low: assert property (p_hold_low)
    else $error("clock line not held low");
  property p_slave_quiet;
    !master_select_out && !cmd_busy_out |-> !clock_line_pin_oe_out;
  endproperty
  a_slave_quiet: assert property (p_slave_quiet)
    else $error("clock line driven outside master mode");
  property p_busy_len; $rose(cmd_busy_out) |-> ##[1:200] !cmd_busy_out; endproperty
  a_busy_len: assert property (p_busy_len)
    else $error("command busy too long");
  property p_taken; (data_wr_in || data_rd_in) && !cmd_busy_out |=> cmd_busy_out; endproperty
  a_taken: assert property (p_taken)
    else $error("buffer strobe not taken");
  property p_frame_irq; $rose(master_select_out) |-> ##[1:1000] bus_interface_irq_out; endproperty
  a_frame_irq: assert property (p_frame_irq)
    else $error("no irq after address word");
  property p_gc_en; $rose(general_call_flag_out) |-> !address_detect_disable_in; endproperty
  a_gc_en: assert property (p_gc_en)
    else $error("general call flag set while detection off");
  property p_aas_en;
    $rose(addressed_as_slave_flag_out) |-> !address_detect_disable_in;
  endproperty
  a_aas_en: assert property (p_aas_en)
    else $error("addressed flag set while detection off");
  property p_aas_clear;
    data_rd_in && !cmd_busy_out && !bus_busy_flag_out |-> ##[1:60] !addressed_as_slave_flag_out;
  endproperty
  a_aas_clear: assert property (p_aas_clear)
    else $error("addressed flag not cleared by read");
  property p_resume;
    data_wr_in && !cmd_busy_out && master_select_out |-> ##[1:60] service_request_out;
  endproperty
  a_resume: assert property (p_resume)
    else $error("buffer write did not set service request");

  c_irq: cover property (bus_interface_irq_out);
  c_gc: cover property ($rose(general_call_flag_out));
  c_aas: cover property ($rose(addressed_as_slave_flag_out));
endmodule : ismt_properties

// ### ismt_peer.sv
`timescale 1ns/1ns
module ismt_peer (
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  input  wire logic       ack_in,
  output logic            scl_oe_out,
  output logic            sda_oe_out,
  output logic      [7:0] rx_byte_out,
  output logic            rx_tgl_out
);
  logic ack_oe, drv_sda, mastering, active, sda_dly;
  int   nb;

  // Delayed view so a data change at the SCL fall is no false start
  assign #10 sda_dly = sda_in;
  assign sda_oe_out = ack_oe | drv_sda;
  initial begin
    {scl_oe_out, rx_tgl_out, ack_oe, drv_sda, mastering, active} = 6'h00;
    rx_byte_out = 8'h00;
  end
  always @(negedge sda_dly) begin
    if (scl_in && !mastering) begin
      active = 1'b1;
      nb = 0;
    end
  end
  always @(posedge sda_dly) if (scl_in) active = 1'b0;
  always @(posedge scl_in) begin
    if (active && nb < 8) begin
      rx_byte_out = {rx_byte_out[6:0], sda_in};
      nb++;
    end
  end
  always @(negedge scl_in) begin
    if (active && nb == 8) begin
      ack_oe = ack_in;
      nb = 9;
      rx_tgl_out = ~rx_tgl_out;
    end else if (active && nb == 9) begin
      ack_oe = 1'b0;
      nb = 0;
    end
  end
  // Peer as bus master: start, eight bits, open acknowledge slot
  task automatic send(input logic [7:0] b, input logic stp);
    mastering = 1'b1;
    active = 1'b0;
    scl_oe_out = 1'b0;
    #600 drv_sda = 1'b1;
    #600 scl_oe_out = 1'b1;
    #300;
    for (int i = 8; i >= 0; i--) begin
      drv_sda = (i > 0) ? ~b[i-1] : 1'b0;
      #300 scl_oe_out = 1'b0;
      #600 scl_oe_out = 1'b1;
      #300;
    end
    if (stp) begin
      drv_sda = 1'b1;
      #300 scl_oe_out = 1'b0;
      #600 drv_sda = 1'b0;
      #600;
    end
    mastering = 1'b0;
  endtask : send
endmodule : ismt_peer

// ### ismt_tb_top.sv
`timescale 1ns/1ns
module ismt_tb_top;
  logic       clock_in, sys_rst_in, link_clk_in, ctrl_wr_in, data_wr_in, data_rd_in;
  logic       ctrl_master_select_in, ctrl_transmit_in, ctrl_bus_busy_in, ctrl_service_req_in;
  logic       ack_clock_enable_in, address_detect_disable_in, free_format_select_in;
  logic [7:0] data_wr_data_in, data_rd_data_out, peer_rx, a, d;
  logic [2:0] word_bit_count_in, scl_time_code_in;
  logic [6:0] own_slave_address_in;
  logic       clock_line_pin_in, data_line_pin_in, cmd_busy_out, master_select_out;
  logic       transmit_select_out, bus_busy_flag_out, service_request_out, peer_tgl;
  logic       addressed_as_slave_flag_out, general_call_flag_out, last_received_bit_out;
  logic       bus_interface_irq_out, clock_line_pin_out, clock_line_pin_oe_out, peer_ack;
  logic       data_line_pin_out, data_line_pin_oe_out, peer_scl_oe, peer_sda_oe;
  logic [7:0] exp_b[$];
  logic       exp_l[$];
  int         err_total, compares, irq_cnt, cyc;

  assign clock_line_pin_in = ~(clock_line_pin_oe_out | peer_scl_oe);
  assign data_line_pin_in  = ~(data_line_pin_oe_out | peer_sda_oe);

  ismt_core DUT (.*);
  ismt_peer peer (.scl_in(clock_line_pin_in), .sda_in(data_line_pin_in), .ack_in(peer_ack),
    .scl_oe_out(peer_scl_oe), .sda_oe_out(peer_sda_oe), .rx_byte_out(peer_rx),
    .rx_tgl_out(peer_tgl));

  initial begin
    clock_in = 1'b0;
    forever #10 clock_in = ~clock_in;
  end
  initial begin
    link_clk_in = 1'b0;
    #37;
    forever begin
      #62 link_clk_in = 1'b1;
      #63 link_clk_in = 1'b0;
    end
  end

  task automatic final_report;
    if (err_total == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : final_report
  task automatic cmp_bit(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_bit
  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_byte
  task automatic settle;
    repeat (60) @(negedge clock_in);
  endtask : settle
  // k: 0 buffer write, 1 control write, 2 buffer read
  task automatic strobe(input int k, input logic [7:0] dv, input logic [3:0] c);
    int n;
    n = 0;
    while (cmd_busy_out !== 1'b0 && n < 500) begin
      @(negedge clock_in);
      n++;
    end
    @(negedge clock_in);
    data_wr_in = k == 0;
    ctrl_wr_in = k == 1;
    data_rd_in = k == 2;
    data_wr_data_in = dv;
    {ctrl_master_select_in, ctrl_transmit_in, ctrl_bus_busy_in, ctrl_service_req_in} = c;
    @(negedge clock_in);
    {data_wr_in, ctrl_wr_in, data_rd_in} = 3'h0;
    repeat (2) @(negedge clock_in);
  endtask : strobe
  task automatic wait_irq;
    int n0;
    n0 = irq_cnt;
    repeat (3000) if (irq_cnt == n0) @(negedge clock_in);
    if (irq_cnt == n0) begin
      err_total++;
      final_report();
    end
    settle();
  endtask : wait_irq
  task automatic slave_case(input logic [7:0] b, input logic dis, ff, stp, eaas, ead0);
    @(negedge clock_in);
    address_detect_disable_in = dis;
    free_format_select_in = ff;
    peer.send(b, stp);
    settle();
    cmp_bit(addressed_as_slave_flag_out, eaas);
    cmp_bit(general_call_flag_out, ead0);
    cmp_bit(last_received_bit_out, !stp);
    strobe(2, 8'h00, 4'h0);
    settle();
    cmp_bit(addressed_as_slave_flag_out, 1'b0);
  endtask : slave_case

  always @(peer_tgl)
    if (exp_b.size() > 0) cmp_byte(peer_rx, exp_b.pop_front());
  always @(negedge clock_in) begin
    if (bus_interface_irq_out === 1'b1) begin
      irq_cnt++;
      if (exp_l.size() > 0) cmp_bit(last_received_bit_out, exp_l.pop_front());
    end
  end
  always @(posedge clock_in) begin
    cyc++;
    if (cyc == 30000) begin
      err_total++;
      final_report();
    end
  end

  initial begin
    void'($urandom(32'hE3657AAF));
    {ctrl_wr_in, data_wr_in, data_rd_in, peer_ack} = 4'h0;
    {ctrl_master_select_in, ctrl_transmit_in, ctrl_bus_busy_in, ctrl_service_req_in} = 4'h0;
    {address_detect_disable_in, free_format_select_in} = 2'h0;
    ack_clock_enable_in = 1'b1;
    word_bit_count_in = 3'h0;
    scl_time_code_in = 3'h0;
    data_wr_data_in = 8'h00;
    own_slave_address_in = 7'($urandom) | 7'h01;
    sys_rst_in = 1'b1;
    repeat (20) @(posedge clock_in);
    @(negedge clock_in);
    sys_rst_in = 1'b0;
    settle();
    cmp_bit(service_request_out, 1'b1);
    cmp_bit(clock_line_pin_oe_out | data_line_pin_oe_out, 1'b0);
    for (int k = 0; k < 3; k++) begin
      a = {7'($urandom), k < 2};
      peer_ack = k != 1;
      exp_b.push_back(a);
      exp_l.push_back(k == 1);
      cmp_bit(bus_busy_flag_out, 1'b0);
      strobe(0, a, 4'h0);
      strobe(1, 8'h00, 4'hF);
      wait_irq();
      cmp_bit(transmit_select_out, k != 0);
      cmp_bit(service_request_out, 1'b0);
      cmp_bit(clock_line_pin_in, 1'b0);
      if (k == 0) begin
        // Master receiver word: nobody drives data, own ack low
        exp_b.push_back(8'hFF);
        exp_l.push_back(1'b0);
        strobe(1, 8'h00, 4'h1);
        wait_irq();
        cmp_byte(data_rd_data_out, 8'hFF);
      end
      for (int j = 0; j < 2 && k == 2; j++) begin
        d = 8'($urandom);
        peer_ack = j == 0;
        exp_b.push_back(d);
        exp_l.push_back(j == 1);
        strobe(0, d, 4'h0);
        wait_irq();
      end
      strobe(1, 8'h00, 4'hD);
      repeat (3) settle();
      cmp_bit(bus_busy_flag_out | master_select_out, 1'b0);
    end
    slave_case({own_slave_address_in, 1'($urandom)}, 0, 0, 1, 1, 0);
    slave_case({own_slave_address_in ^ 7'h40, 1'b0}, 0, 0, 1, 0, 0);
    slave_case(8'h00, 0, 0, 0, 1, 1);
    slave_case(8'h00, 1, 0, 0, 0, 0);
    slave_case({own_slave_address_in, 1'b1}, 1, 0, 1, 0, 0);
    slave_case(8'h00, 0, 0, 1, 1, 0);
    slave_case(8'($urandom) | 8'h01, 0, 1, 1, 1, 0);
    final_report();
  end
endmodule : ismt_tb_top

bind ismt_core ismt_properties u_props (
  .clock_in(clock_in), .sys_rst_in(sys_rst_in), .data_wr_in(data_wr_in),
  .data_rd_in(data_rd_in), .address_detect_disable_in(address_detect_disable_in),
  .cmd_busy_out(cmd_busy_out), .master_select_out(master_select_out),
  .bus_busy_flag_out(bus_busy_flag_out), .service_request_out(service_request_out),
  .addressed_as_slave_flag_out(addressed_as_slave_flag_out),
  .general_call_flag_out(general_call_flag_out),
  .bus_interface_irq_out(bus_interface_irq_out),
  .clock_line_pin_oe_out(clock_line_pin_oe_out)
);
